// [bench/framer_slot_model.sv]
// Framer slot side model: strobes slot and data link bits, gathers inserted bits.
module framer_slot_model
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  txBit,
  input  wire logic  txInsert,
  output logic       chanStrobe,
  output logic [4:0] chanNum,
  output logic [2:0] chanBitPos,
  output logic       fdlStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       got[$];
  logic [4:0] slotCnt;
  // ==========================================================================
  // Strobes for channels 0 to 3, eight bits each.
  initial
  begin
    slotCnt = 5'h00;
    chanStrobe = 1'b0;
    chanNum = 5'h00;
    chanBitPos = 3'h0;
    fdlStrobe = 1'b0;
    forever
    begin
      @(negedge clk);
      slotCnt = rst_n ? slotCnt + 5'h01 : 5'h00;
      chanStrobe = rst_n;
      chanNum = {3'h0, slotCnt[4:3]};
      chanBitPos = slotCnt[2:0];
      fdlStrobe = rst_n & slotCnt[0];
    end
  end
  always @(posedge clk)
    if (txInsert === 1'b1)
      got.push_back(txBit);
endmodule

// [bench/transmit_hdlc_controller_bench.sv]
// Self-checking bench for the transmit HDLC controller.
bind tx_hdlc_controller tx_hdlc_controller_chk u_chk (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .fdlEnable(fdlEnable), .chanStrobe(chanStrobe),
  .chanNum(chanNum), .chanBitPos(chanBitPos), .fdlStrobe(fdlStrobe), .txInsert(txInsert));
module transmit_hdlc_controller_bench
  import tx_hdlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst_n, regWrEn, regRdEn, t1Mode, fdlEnable, chanStrobe;
  logic              fdlStrobe, txBit, txInsert, fifoReady;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0]        regWrData, regRdData, rdVal;
  logic [4:0]        chanNum;
  logic [2:0]        chanBitPos;
  logic              exp[$];
  int                ones, errors, n_checks;
  tx_hdlc_controller u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .t1Mode(t1Mode), .fdlEnable(fdlEnable), .chanStrobe(chanStrobe), .chanNum(chanNum),
    .chanBitPos(chanBitPos), .fdlStrobe(fdlStrobe), .txBit(txBit), .txInsert(txInsert),
    .fifoReady(fifoReady));
  framer_slot_model u_link (.clk(clk), .rst_n(rst_n), .txBit(txBit), .txInsert(txInsert),
    .chanStrobe(chanStrobe), .chanNum(chanNum), .chanBitPos(chanBitPos),
    .fdlStrobe(fdlStrobe));
  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string msg);
    errors++;
    $display("FAIL %0t %s", $time, msg);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    rdVal = regRdData;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    n_checks++;
    if (rdVal !== e)
      fail($sformatf("reg %h read %h expected %h", a, rdVal, e));
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic put(input logic [7:0] b, input bit s);
    for (int i = 0; i < 8; i++)
    begin
      exp.push_back(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (s && ones == 5)
      begin
        exp.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic build(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
                       input int n);
    logic [15:0] crc;
    crc = crc_step(crc_step(CRC_INIT, d0), d1);
    exp.delete();
    put(FLAG_BYTE, 1'b0);
    repeat (n)
    begin
      ones = 0;
      put(d0, !c[ZERO_STUFFER_DEFEAT]);
      put(d1, !c[ZERO_STUFFER_DEFEAT]);
      if (!c[CRC_DEFEAT])
      begin
        put(~crc[7:0], !c[ZERO_STUFFER_DEFEAT]);
        put(~crc[15:8], !c[ZERO_STUFFER_DEFEAT]);
      end
      put(FLAG_BYTE, 1'b0);
    end
    if (n == 1 && c[FLAG_COUNT_SELECT])
      put(FLAG_BYTE, 1'b0);
    if (n == 1)
      put(c[FILL_SELECT] ? IDLE_BYTE : FLAG_BYTE, 1'b0);
  endtask
  function automatic bit seen();
    for (int i = 0; i + exp.size() <= u_link.got.size(); i++)
    begin
      int k;
      k = 0;
      while (k < exp.size() && u_link.got[i + k] === exp[k])
        k++;
      if (k == exp.size())
        return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic expect_stream(input string what);
    int n;
    n = 0;
    while (!seen() && n < 600)
    begin
      repeat (8) @(negedge clk);
      n++;
    end
    n_checks++;
    if (n == 600)
    begin
      fail(what);
      end_sim();
    end
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] last, input logic [7:0] d0,
                      input logic [7:0] d1);
    u_link.got.delete();
    wr(ADDR_CTL_ONE, c);
    wr(ADDR_FIFO_PORT, d0);
    wr(ADDR_CTL_ONE, c | last);
    wr(ADDR_FIFO_PORT, d1);
  endtask
  // ==========================================================================
  // Clock and main sequence
  initial
  begin
    clk = 1'b0;
    forever
      #50 clk = ~clk;
  end
  initial
  begin
    logic [11:0] addrs [5] = '{ADDR_CTL_ONE, ADDR_SUPPRESS, ADDR_CTL_TWO, ADDR_FIFO_PORT, 12'h117};
    logic [7:0]  ctls [3] = '{8'h00, 8'h88, 8'h0B};
    int          n;
    {rst_n, regWrEn, regRdEn, t1Mode, fdlEnable} = 5'h00;
    {regAddr, regWrData, errors, n_checks, ones, n} = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    foreach (addrs[i])
      rd_chk(addrs[i], 8'h00);
    wr(ADDR_SUPPRESS, 8'h81);
    rd_chk(ADDR_SUPPRESS, 8'h81);
    wr(ADDR_CTL_TWO, 8'h23);
    rd_chk(ADDR_CTL_TWO, 8'h23);
    u_link.got.delete();
    wr(ADDR_CTL_ONE, 8'h20);
    rdVal = 8'hFF;
    while (rdVal[TX_CONTROLLER_RESET] !== 1'b0 && n < RESET_LIMIT_CYC)
    begin
      rd(ADDR_CTL_ONE);
      n += 2;
    end
    n_checks++;
    if (n >= RESET_LIMIT_CYC)
    begin
      fail("reset bit stuck");
      end_sim();
    end
    exp.delete();
    put(ABORT_BYTE, 1'b0);
    put(FLAG_BYTE, 1'b0);
    expect_stream("no abort after reset");
    foreach (ctls[i])
    begin
      build(ctls[i], 8'hFF, 8'h3E, 1);
      send(ctls[i], 8'h04, 8'hFF, 8'h3E);
      expect_stream("frame not seen");
    end
    build(8'h00, 8'hA5, 8'h7F, 2);
    send(8'h00, 8'h40, 8'hA5, 8'h7F);
    expect_stream("loop not repeated");
    u_link.got.delete();
    wr(ADDR_CTL_ONE, 8'h00);
    exp.delete();
    repeat (3) put(FLAG_BYTE, 1'b0);
    expect_stream("loop not ended");
    u_link.got.delete();
    n = 0;
    while (fifoReady === 1'b1 && n < 16)
    begin
      wr(ADDR_FIFO_PORT, 8'h55);
      n++;
    end
    n_checks++;
    if (n != FIFO_DEPTH)
      fail("buffer full flag wrong");
    wr(ADDR_CTL_TWO, 8'hA3);
    exp.delete();
    put(ABORT_BYTE, 1'b0);
    put(FLAG_BYTE, 1'b0);
    expect_stream("no abort byte");
    rd_chk(ADDR_STATUS, 8'h04);
    wr(ADDR_CTL_TWO, 8'h23);
    t1Mode = 1'b1;
    fdlEnable = 1'b1;
    wr(ADDR_CODE, 8'h15);
    wr(ADDR_CTL_ONE, 8'h10);
    u_link.got.delete();
    wr(ADDR_CTL_TWO, 8'h60);
    exp.delete();
    put(8'h2A, 1'b0);
    put(BOC_ONES, 1'b0);
    put(8'h2A, 1'b0);
    expect_stream("code word not seen");
    rd_chk(ADDR_CTL_ONE, 8'h10);
    end_sim();
  end
endmodule

// [bench/tx_hdlc_controller_chk.sv]
// Port assertions for the transmit HDLC controller.
module tx_hdlc_controller_chk
  import tx_hdlc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [7:0]        regRdData,
  input wire logic              fdlEnable,
  input wire logic              chanStrobe,
  input wire logic [4:0]        chanNum,
  input wire logic [2:0]        chanBitPos,
  input wire logic              fdlStrobe,
  input wire logic              txInsert
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] one, two, sup; logic [4:0] chan; logic [11:0] hold;} shadow_s;
  shadow_s shReg, shNext;
  logic    slotOk, fdlOk, rstWr;
  // ==========================================================================
  // Register shadows
  assign rstWr = regWrEn && regAddr == ADDR_CTL_ONE && regWrData[TX_CONTROLLER_RESET];
  assign slotOk = chanStrobe && chanNum == shReg.chan && !shReg.sup[chanBitPos]
                  && !shReg.one[MAPPING_SELECT];
  assign fdlOk = fdlStrobe && fdlEnable && shReg.one[MAPPING_SELECT];
  always_comb
  begin
    shNext = shReg;
    if (shReg.hold != 12'hFFF)
      shNext.hold = shReg.hold + 12'h001;
    if (regWrEn && regAddr == ADDR_CTL_ONE)
      shNext.one = regWrData;
    if (regWrEn && regAddr == ADDR_CTL_TWO)
      shNext.two = regWrData;
    if (regWrEn && regAddr == ADDR_SUPPRESS)
      shNext.sup = regWrData;
    if (rstWr)
    begin
      shNext.chan = shReg.two[4:0];
      shNext.hold = 12'h000;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shReg <= {29'h0, 12'hFFF};
    else
      shReg <= shNext;
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  route_take_a: assert property (!slotOk && !fdlOk |=> !txInsert)
    else $error("bit inserted without a taken strobe");
  enable_off_a: assert property (!shReg.two[CONTROLLER_ENABLE] |=> !txInsert)
    else $error("bit inserted while disabled");
  suppress_a: assert property (chanStrobe && shReg.sup[chanBitPos] && !fdlOk |=> !txInsert)
    else $error("suppressed bit position used");
  chan_sel_a: assert property (chanStrobe && chanNum != shReg.chan && !fdlOk |=> !txInsert)
    else $error("bit inserted in another channel");
  reset_quiet_a: assert property (rstWr |-> ##2 (!txInsert) [*8])
    else $error("bits taken during reset hold");
  hold_reads_a: assert property (regRdEn && regAddr == ADDR_CTL_ONE && shReg.hold < 12'h008
    |=> regRdData[TX_CONTROLLER_RESET])
    else $error("reset bit not set during hold");
  self_clear_a: assert property (regRdEn && regAddr == ADDR_CTL_ONE && shReg.hold > RESET_LIMIT_CYC
    |=> !regRdData[TX_CONTROLLER_RESET])
    else $error("reset bit not cleared in time");
  sup_read_a: assert property (regRdEn && regAddr == ADDR_SUPPRESS
    |=> regRdData == $past(shReg.sup))
    else $error("suppress read back wrong");
  cover property (fdlOk ##1 txInsert);
  cover property (slotOk ##1 txInsert);
  cover property (rstWr);
endmodule

// [design/tx_hdlc_controller.sv]
// Transmit HDLC controller: registers, frame builder and time slot bit insertion.
module tx_hdlc_controller
  import tx_hdlc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic [7:0]             regRdData,
  input  wire logic              t1Mode,
  input  wire logic              fdlEnable,
  input  wire logic              chanStrobe,
  input  wire logic [4:0]        chanNum,
  input  wire logic [2:0]        chanBitPos,
  input  wire logic              fdlStrobe,
  output logic                   txBit,
  output logic                   txInsert,
  output logic                   fifoReady
);

  localparam int LAW = $clog2(LOOP_DEPTH);

  typedef struct packed {
    tx_state_e                   state;
    logic [7:0]                  ctlOne;
    logic [7:0]                  ctlTwo;
    logic [7:0]                  suppress;
    logic [5:0]                  code;
    logic                        abortPrev;
    logic [4:0]                  rstCnt;
    logic [7:0]                  shift;
    logic [2:0]                  bitCnt;
    logic [2:0]                  ones;
    logic [1:0]                  flagsLeft;
    logic                        lastByte;
    logic                        replay;
    logic                        looping;
    logic                        loopOk;
    logic [LAW:0]                capLen;
    logic [LAW:0]                rdIdx;
    logic [LOOP_DEPTH-1:0][7:0]  loopMem;
    logic [4:0]                  activeChan;
    logic [3:0]                  bocIdx;
    logic [7:0]                  rdData;
    logic                        txBit;
    logic                        txInsert;
  } ctrl_s;

  ctrl_s                  st_reg;
  ctrl_s                  st_next;
  logic                   fifoPush;
  logic                   fifoPop;
  logic                   fifoFlush;
  logic                   fifoValid;
  logic [FIFO_WIDTH-1:0]  fifoOut;
  logic                   crcInit;
  logic                   crcEn;
  logic [15:0]            crcNext;
  logic [15:0]            crcOut;
  logic                   take;
  logic                   bocMode;
  logic                   msgField;
  logic                   outBit;
  logic [15:0]            bocWord;
  logic [7:0]             fillByte;

  // ==========================================================================
  // Transmit FIFO and check sequence generator
  tx_hdlc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (fifoFlush),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .inData   ({st_reg.ctlOne[LOOP_MESSAGE_BIT], st_reg.ctlOne[END_OF_MESSAGE_BIT], regWrData}),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  tx_hdlc_crc16 u_crc (
    .clk     (clk),
    .rst_n   (rst_n),
    .init    (crcInit),
    .bitEn   (crcEn),
    .bitIn   (st_reg.shift[0]),
    .crcNext (crcNext),
    .crcOut  (crcOut)
  );

  assign regRdData = st_reg.rdData;
  assign txBit     = st_reg.txBit;
  assign txInsert  = st_reg.txInsert;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next   = st_reg;
    fifoPush  = 1'b0;
    fifoPop   = 1'b0;
    fifoFlush = 1'b0;
    crcInit   = 1'b0;
    crcEn     = 1'b0;
    outBit    = 1'b1;
    fillByte  = st_reg.ctlOne[FILL_SELECT] ? IDLE_BYTE : FLAG_BYTE;
    bocWord   = {BOC_ONES, 1'b0, st_reg.code, 1'b0};
    bocMode   = t1Mode && st_reg.ctlTwo[SEND_BIT_ORIENTED];
    msgField  = (st_reg.state == ST_DATA) || (st_reg.state == ST_CRC_LO)
                || (st_reg.state == ST_CRC_HI);

    // Slot selection: a time slot bit or an FDL/Sa bit is handed to us.
    take = 1'b0;
    if (st_reg.ctlTwo[CONTROLLER_ENABLE] && (st_reg.rstCnt == '0))
    begin
      if (!st_reg.ctlOne[MAPPING_SELECT])
      begin
        take = chanStrobe && (chanNum == st_reg.activeChan)
               && !st_reg.suppress[chanBitPos];
      end
      else
      begin
        take = fdlStrobe && fdlEnable;
      end
    end

    // Self-clearing controller reset countdown.
    if (st_reg.rstCnt != '0)
    begin
      fifoFlush      = 1'b1;
      st_next.rstCnt = st_reg.rstCnt - 1'b1;
      if (st_reg.rstCnt == 5'h01)
      begin
        st_next.ctlOne[TX_CONTROLLER_RESET] = 1'b0;
      end
    end

    // Abort on a rising edge of the abort bit.
    st_next.abortPrev = st_reg.ctlTwo[ABORT_BIT];
    if (st_reg.ctlTwo[ABORT_BIT] && !st_reg.abortPrev)
    begin
      fifoFlush        = 1'b1;
      st_next.state    = ST_ABORT;
      st_next.shift    = ABORT_BYTE;
      st_next.bitCnt   = '0;
      st_next.ones     = '0;
      st_next.looping  = 1'b0;
      st_next.replay   = 1'b0;
    end
    else if (take)
    begin
      if (bocMode && st_reg.ctlOne[MAPPING_SELECT])
      begin
        outBit         = bocWord[st_reg.bocIdx];
        st_next.bocIdx = st_reg.bocIdx + 1'b1;
      end
      else if (!st_reg.ctlOne[ZERO_STUFFER_DEFEAT] && (st_reg.ones == ONES_LIMIT))
      begin
        outBit       = 1'b0;
        st_next.ones = '0;
      end
      else
      begin
        outBit         = st_reg.shift[0];
        st_next.shift  = {1'b1, st_reg.shift[7:1]};
        st_next.ones   = (msgField && st_reg.shift[0]) ? st_reg.ones + 1'b1 : '0;
        crcEn          = (st_reg.state == ST_DATA);
        st_next.bitCnt = st_reg.bitCnt + 1'b1;
        if (st_reg.bitCnt == 3'h7)
        begin
          case (st_reg.state)
            ST_FILL:
            begin
              if (fifoValid)
              begin
                st_next.state     = ST_FLAGS;
                st_next.shift     = FLAG_BYTE;
                st_next.flagsLeft = 2'h1;
              end
              else
              begin
                st_next.shift = fillByte;
              end
            end
            ST_FLAGS:
            begin
              if (st_reg.flagsLeft > 2'h1)
              begin
                st_next.flagsLeft = st_reg.flagsLeft - 1'b1;
                st_next.shift     = FLAG_BYTE;
              end
              else if (fifoValid)
              begin
                fifoPop          = 1'b1;
                crcInit          = 1'b1;
                st_next.state    = ST_DATA;
                st_next.shift    = fifoOut[7:0];
                st_next.lastByte = fifoOut[8] || fifoOut[9];
                st_next.looping  = fifoOut[9];
                st_next.replay   = 1'b0;
                st_next.loopOk   = 1'b1;
                st_next.loopMem[0] = fifoOut[7:0];
                st_next.capLen   = (LAW+1)'(1);
              end
              else if (st_reg.looping && st_reg.loopOk && st_reg.ctlOne[LOOP_MESSAGE_BIT])
              begin
                crcInit          = 1'b1;
                st_next.state    = ST_DATA;
                st_next.replay   = 1'b1;
                st_next.rdIdx    = '0;
                st_next.shift    = st_reg.loopMem[0];
                st_next.lastByte = (st_reg.capLen == (LAW+1)'(1));
              end
              else
              begin
                st_next.state   = ST_FILL;
                st_next.looping = 1'b0;
                st_next.shift   = fillByte;
              end
            end
            ST_DATA:
            begin
              if (st_reg.lastByte)
              begin
                if (st_reg.ctlOne[CRC_DEFEAT])
                begin
                  st_next.state     = ST_FLAGS;
                  st_next.shift     = FLAG_BYTE;
                  st_next.flagsLeft = st_reg.ctlOne[FLAG_COUNT_SELECT] ? 2'h2 : 2'h1;
                end
                else
                begin
                  st_next.state = ST_CRC_LO;
                  st_next.shift = ~crcNext[7:0];
                end
              end
              else if (st_reg.replay)
              begin
                st_next.rdIdx    = st_reg.rdIdx + 1'b1;
                st_next.shift    = st_reg.loopMem[st_reg.rdIdx[LAW-1:0] + 1'b1];
                st_next.lastByte = ((st_reg.rdIdx + (LAW+1)'(2)) == st_reg.capLen);
              end
              else if (fifoValid)
              begin
                fifoPop          = 1'b1;
                st_next.shift    = fifoOut[7:0];
                st_next.lastByte = fifoOut[8] || fifoOut[9];
                st_next.looping  = fifoOut[9];
                if (st_reg.capLen == (LAW+1)'(LOOP_DEPTH))
                begin
                  st_next.loopOk = 1'b0;
                end
                else
                begin
                  st_next.loopMem[st_reg.capLen[LAW-1:0]] = fifoOut[7:0];
                  st_next.capLen = st_reg.capLen + 1'b1;
                end
              end
              else
              begin
                st_next.state   = ST_ABORT;
                st_next.shift   = ABORT_BYTE;
                st_next.ones    = '0;
                st_next.looping = 1'b0;
              end
            end
            ST_CRC_LO:
            begin
              st_next.state = ST_CRC_HI;
              st_next.shift = ~crcOut[15:8];
            end
            ST_CRC_HI:
            begin
              st_next.state     = ST_FLAGS;
              st_next.shift     = FLAG_BYTE;
              st_next.flagsLeft = st_reg.ctlOne[FLAG_COUNT_SELECT] ? 2'h2 : 2'h1;
            end
            ST_ABORT:
            begin
              st_next.state = ST_FILL;
              st_next.shift = fillByte;
            end
            default:
            begin
              st_next.state = ST_FILL;
              st_next.shift = fillByte;
            end
          endcase
        end
      end
    end
    st_next.txInsert = take;
    if (take)
    begin
      st_next.txBit = outBit;
    end

    // Register writes.
    if (regWrEn)
    begin
      case (regAddr)
        ADDR_CTL_ONE:
        begin
          st_next.ctlOne = regWrData;
          if (regWrData[TX_CONTROLLER_RESET])
          begin
            st_next.rstCnt     = RESET_HOLD_CYC;
            st_next.state      = ST_ABORT;
            st_next.shift      = ABORT_BYTE;
            st_next.bitCnt     = '0;
            st_next.ones       = '0;
            st_next.looping    = 1'b0;
            st_next.replay     = 1'b0;
            st_next.activeChan = st_reg.ctlTwo[CHAN_SEL_MSB:0];
          end
        end
        ADDR_SUPPRESS:
        begin
          st_next.suppress = regWrData;
        end
        ADDR_FIFO_PORT:
        begin
          fifoPush = (st_reg.rstCnt == '0);
        end
        ADDR_CTL_TWO:
        begin
          st_next.ctlTwo = regWrData;
        end
        ADDR_CODE:
        begin
          st_next.code = regWrData[5:0];
        end
        default:
        begin
          st_next.code = st_reg.code;
        end
      endcase
    end

    // Register reads.
    if (regRdEn)
    begin
      case (regAddr)
        ADDR_CTL_ONE:  st_next.rdData = st_reg.ctlOne;
        ADDR_SUPPRESS: st_next.rdData = st_reg.suppress;
        ADDR_CTL_TWO:  st_next.rdData = st_reg.ctlTwo;
        ADDR_CODE:     st_next.rdData = {2'b00, st_reg.code};
        ADDR_STATUS:   st_next.rdData = {5'b00000, fifoReady, st_reg.looping,
                                         (st_reg.state != ST_FILL)};
        default:       st_next.rdData = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.state    <= ST_FILL;
      st_reg.ctlOne   <= CTL_ONE_RESET;
      st_reg.ctlTwo   <= CTL_TWO_RESET;
      st_reg.suppress <= SUPPRESS_RESET;
      st_reg.shift    <= FLAG_BYTE;
      st_reg.txBit    <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// [design/tx_hdlc_crc16.sv]
// Bit-serial frame check sequence generator, reflected form.
module tx_hdlc_crc16
  import tx_hdlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        init,
  input  wire logic        bitEn,
  input  wire logic        bitIn,
  output logic [15:0]      crcNext,
  output logic [15:0]      crcOut
);

  typedef struct packed {
    logic [15:0] crc;
  } crc_s;

  crc_s st_reg;
  crc_s st_next;

  assign crcOut = st_reg.crc;

  // ==========================================================================
  // Next state
  always_comb
  begin
    crcNext = (st_reg.crc >> 1) ^ ((st_reg.crc[0] ^ bitIn) ? CRC_POLY : 16'h0000);
    st_next = st_reg;
    if (init)
    begin
      st_next.crc = CRC_INIT;
    end
    else if (bitEn)
    begin
      st_next.crc = crcNext;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.crc <= CRC_INIT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// [design/tx_hdlc_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides and a flush.
module tx_hdlc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [CW-1:0]               count;
    logic                        notFull;
    logic                        notEmpty;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic  push;
  logic  pop;

  assign inReady  = st_reg.notFull;
  assign outValid = st_reg.notEmpty;
  assign outData  = st_reg.mem[st_reg.rdPtr];

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    push    = inValid && st_reg.notFull;
    pop     = outReady && st_reg.notEmpty;
    if (push)
    begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr = (st_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : st_reg.wrPtr + 1'b1;
    end
    if (pop)
    begin
      st_next.rdPtr = (st_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : st_reg.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
    if (flush)
    begin
      st_next.wrPtr = '0;
      st_next.rdPtr = '0;
      st_next.count = '0;
    end
    st_next.notFull  = (st_next.count != CW'(DEPTH));
    st_next.notEmpty = (st_next.count != '0);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.notFull  <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// [design/tx_hdlc_pkg.sv]
// Package of register map, field positions, codes and timing for the transmit HDLC controller.
package tx_hdlc_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] ADDR_CTL_ONE      = 12'h110;
  localparam logic [11:0] ADDR_SUPPRESS     = 12'h111;
  localparam logic [11:0] ADDR_FIFO_PORT    = 12'h112;
  localparam logic [11:0] ADDR_CTL_TWO      = 12'h113;
  localparam logic [11:0] ADDR_CODE         = 12'h115;
  localparam logic [11:0] ADDR_STATUS       = 12'h116;
  localparam logic [7:0]  CTL_ONE_RESET     = 8'h00;
  localparam logic [7:0]  SUPPRESS_RESET    = 8'h00;
  localparam logic [7:0]  CTL_TWO_RESET     = 8'h00;

  // ==========================================================================
  // Control field positions
  localparam int FLAG_COUNT_SELECT   = 7;
  localparam int LOOP_MESSAGE_BIT    = 6;
  localparam int TX_CONTROLLER_RESET = 5;
  localparam int MAPPING_SELECT      = 4;
  localparam int FILL_SELECT         = 3;
  localparam int END_OF_MESSAGE_BIT  = 2;
  localparam int ZERO_STUFFER_DEFEAT = 1;
  localparam int CRC_DEFEAT          = 0;
  localparam int ABORT_BIT           = 7;
  localparam int SEND_BIT_ORIENTED   = 6;
  localparam int CONTROLLER_ENABLE   = 5;
  localparam int CHAN_SEL_MSB        = 4;

  // ==========================================================================
  // Line codes
  localparam logic [7:0]  FLAG_BYTE   = 8'h7E;
  localparam logic [7:0]  IDLE_BYTE   = 8'hFF;
  localparam logic [7:0]  ABORT_BYTE  = 8'hFE;
  localparam logic [7:0]  BOC_ONES    = 8'hFF;
  localparam logic [2:0]  ONES_LIMIT  = 3'h5;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h8408;

  // ==========================================================================
  // Buffers and timing
  localparam int FIFO_WIDTH      = 10;
  localparam int FIFO_DEPTH      = 8;
  localparam int LOOP_DEPTH      = 16;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RESET_LIMIT_NS  = 250000;
  localparam int RESET_LIMIT_CYC = RESET_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_HOLD_CYC = 5'h10;

  typedef enum logic [2:0] {ST_FILL, ST_FLAGS, ST_DATA, ST_CRC_LO, ST_CRC_HI, ST_ABORT}
    tx_state_e;

endpackage
